// ### hdl/uart_irq_pkg.sv
package uart_irq_pkg;
  // register offsets on the peripheral bus (byte addresses)
  localparam logic [11:0] MASK_OFFSET   = 12'h038;
  localparam logic [11:0] MIS_OFFSET    = 12'h040;
  localparam logic [11:0] ICR_OFFSET    = 12'h044;
  localparam logic [11:0] DMACR_OFFSET  = 12'h048;
  // interrupt source bit positions, shared by status, mask and clear
  localparam int NUM_SRC       = 11;
  localparam int OVERRUN_BIT   = 10;
  localparam int BREAK_BIT     = 9;
  localparam int PARITY_BIT    = 8;
  localparam int FRAMING_BIT   = 7;
  localparam int RX_TIMEOUT_BIT = 6;
  localparam int TX_BIT        = 5;
  localparam int RX_BIT        = 4;
  localparam int DSR_BIT       = 3;
  localparam int DCD_BIT       = 2;
  localparam int CTS_BIT       = 1;
  localparam int RING_BIT      = 0;
  localparam int NUM_MODEM     = 4;
  // dma control bit positions
  localparam int RX_DMA_EN_BIT    = 0;
  localparam int TX_DMA_EN_BIT    = 1;
  localparam int DMA_ON_ERR_BIT   = 2;
  localparam int DMACR_WIDTH      = 3;
  // values after reset
  localparam logic [NUM_SRC-1:0]     FLAGS_RESET = 11'h000;
  localparam logic [NUM_SRC-1:0]     MASK_RESET  = 11'h000;
  localparam logic [DMACR_WIDTH-1:0] DMACR_RESET = 3'h0;
  localparam logic [31:0]            RDATA_RESET = 32'h0000_0000;
endpackage

// ### hdl/irq_flag_if.sv
`timescale 1ns/1ps
interface irq_flag_if;
  import uart_irq_pkg::*;
  logic [NUM_SRC-1:0] set_evt;   // one-cycle set pulses, overrun is a level
  logic [NUM_SRC-1:0] clr;       // one-cycle clear pulses from the bus
  logic [NUM_SRC-1:0] flags;     // raw flags, held except overrun which is live
  modport owner (input set_evt, input clr, output flags);
  modport user  (output set_evt, output clr, input flags);
endinterface

// ### hdl/irq_flag_store.sv
`timescale 1ns/1ps
module irq_flag_store
  import uart_irq_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  reset,
  irq_flag_if.owner  fl
);
  genvar i;
  // one storage element per source; overrun passes straight through
  generate
    for (i = 0; i < NUM_SRC; i++)
    begin : g_flag
      if (i == OVERRUN_BIT)
      begin : g_live
        assign fl.flags[i] = fl.set_evt[i]; // live, not held
      end
      else
      begin : g_held
        logic flag_q;
        // set beats clear in the same cycle
        always_ff @(posedge sys_clk)
        begin
          if (reset)
            flag_q <= FLAGS_RESET[i];
          else if (fl.set_evt[i])
            flag_q <= 1'b1;
          else if (fl.clr[i])
            flag_q <= 1'b0;
        end
        assign fl.flags[i] = flag_q;
        // held flag drops one cycle after a lone clear
        property p_clear_drops;
          @(posedge sys_clk) disable iff (reset)
            fl.clr[i] && !fl.set_evt[i] |=> !fl.flags[i];
        endproperty
        a_clear_drops: assert property (p_clear_drops)
          else $error("flag not cleared by write of one");
        // a held flag stays set until cleared
        property p_flag_holds;
          @(posedge sys_clk) disable iff (reset)
            fl.flags[i] && !fl.clr[i] |=> fl.flags[i];
        endproperty
        a_flag_holds: assert property (p_flag_holds)
          else $error("held flag dropped without a clear");
      end
    end
  endgenerate
endmodule

// ### hdl/uart_irq_status_dma_ctrl.sv
`timescale 1ns/1ps
module uart_irq_status_dma_ctrl
  import uart_irq_pkg::*;
#(
  parameter int FIFO_CNT_W = 6
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  overrun_live,
  input  wire logic                  break_evt,
  input  wire logic                  parity_evt,
  input  wire logic                  framing_evt,
  input  wire logic                  rx_timeout_evt,
  input  wire logic                  tx_evt,
  input  wire logic                  rx_evt,
  input  wire logic [NUM_MODEM-1:0]  modem_pins,
  input  wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
  input  wire logic [FIFO_CNT_W-1:0] tx_fifo_space,
  input  wire logic [FIFO_CNT_W-1:0] rx_watermark,
  input  wire logic [FIFO_CNT_W-1:0] tx_watermark,
  output logic                       uart_irq,
  output logic                       rx_dma_single_request,
  output logic                       rx_dma_burst_request,
  output logic                       tx_dma_single_request,
  output logic                       tx_dma_burst_request
);
  irq_flag_if fl ();

  logic [NUM_SRC-1:0]     mask_q;
  logic [DMACR_WIDTH-1:0] dmacr_q;
  logic [NUM_MODEM-1:0]   modem_meta_q;
  logic [NUM_MODEM-1:0]   modem_sync_q;
  logic [NUM_MODEM-1:0]   modem_prev_q;
  logic [NUM_SRC-1:0]     masked_irq_status;
  logic                   setup_phase;
  logic                   wr_en;
  logic                   hit_mask;
  logic                   hit_mis;
  logic                   hit_icr;
  logic                   hit_dmacr;
  logic                   err_pending;
  logic                   rx_dma_allow;
  logic                   tx_dma_allow;

  // address decode; every access finishes in its access phase
  assign hit_mask    = (paddr == MASK_OFFSET);
  assign hit_mis     = (paddr == MIS_OFFSET);
  assign hit_icr     = (paddr == ICR_OFFSET);
  assign hit_dmacr   = (paddr == DMACR_OFFSET);
  assign setup_phase = psel && !penable;
  assign wr_en       = psel && penable && pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable &&
                       !(hit_mask || hit_mis || hit_icr || hit_dmacr);

  // modem pins cross into the bus clock through two flops; they keep
  // sampling through reset so a pin idling high gives no false edge
  always_ff @(posedge sys_clk)
  begin
    modem_meta_q <= modem_pins;
    modem_sync_q <= modem_meta_q;
    modem_prev_q <= modem_sync_q;
  end

  // sources into the flag store, in status layout order
  always_comb
  begin
    fl.set_evt                 = '0;
    fl.set_evt[OVERRUN_BIT]    = overrun_live;
    fl.set_evt[BREAK_BIT]      = break_evt;
    fl.set_evt[PARITY_BIT]     = parity_evt;
    fl.set_evt[FRAMING_BIT]    = framing_evt;
    fl.set_evt[RX_TIMEOUT_BIT] = rx_timeout_evt;
    fl.set_evt[TX_BIT]         = tx_evt;
    fl.set_evt[RX_BIT]         = rx_evt;
    fl.set_evt[NUM_MODEM-1:0]  = modem_sync_q ^ modem_prev_q; // any edge
  end

  // clear pulses: only ones written to the clear register act
  assign fl.clr = (wr_en && hit_icr) ?
                  pwdata[NUM_SRC-1:0] : '0;

  irq_flag_store u_flags (
    .sys_clk (sys_clk),
    .reset   (reset),
    .fl      (fl)
  );

  // mask register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mask_q <= MASK_RESET;
    else if (wr_en && hit_mask)
      mask_q <= pwdata[NUM_SRC-1:0];
  end

  // dma control, upper bits dropped on write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      dmacr_q <= DMACR_RESET;
    else if (wr_en && hit_dmacr)
      dmacr_q <= pwdata[DMACR_WIDTH-1:0];
  end

  // masked view and combined interrupt
  assign masked_irq_status = fl.flags & mask_q;
  assign uart_irq          = |masked_irq_status;

  // read data captured in the setup phase, held for the access phase
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prdata <= RDATA_RESET;
    else if (setup_phase)
    begin
      prdata <= RDATA_RESET;
      if (!pwrite && hit_mis)
        prdata[NUM_SRC-1:0] <= masked_irq_status;
      else if (!pwrite && hit_mask)
        prdata[NUM_SRC-1:0] <= mask_q;
      else if (!pwrite && hit_dmacr)
        prdata[DMACR_WIDTH-1:0] <= dmacr_q;
    end
  end

  // dma request gating
  assign err_pending  = |masked_irq_status[OVERRUN_BIT:FRAMING_BIT];
  assign rx_dma_allow = dmacr_q[RX_DMA_EN_BIT] &&
                        !(dmacr_q[DMA_ON_ERR_BIT] && err_pending);
  assign tx_dma_allow = dmacr_q[TX_DMA_EN_BIT];

  // burst when a watermark's worth is there, single whenever any data is there
  assign rx_dma_burst_request  = rx_dma_allow &&
                                 (rx_fifo_count >= rx_watermark) &&
                                 (rx_fifo_count != '0);
  assign rx_dma_single_request = rx_dma_allow &&
                                 (rx_fifo_count != '0);
  assign tx_dma_burst_request  = tx_dma_allow &&
                                 (tx_fifo_space >= tx_watermark) &&
                                 (tx_fifo_space != '0);
  assign tx_dma_single_request = tx_dma_allow && (tx_fifo_space != '0);

  // a write of one to the clear register drops a held masked bit
  property p_mis_clear;
    @(posedge sys_clk) disable iff (reset)
      wr_en && hit_icr && pwdata[BREAK_BIT] && !break_evt
      |=> !masked_irq_status[BREAK_BIT];
  endproperty
  a_mis_clear: assert property (p_mis_clear)
    else $error("break status survived clear write");

  // a zero written to the clear register keeps a pending framing flag
  property p_zero_keeps;
    @(posedge sys_clk) disable iff (reset)
      wr_en && hit_icr && !pwdata[FRAMING_BIT] && fl.flags[FRAMING_BIT]
      |=> fl.flags[FRAMING_BIT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("write of zero cleared framing flag");

  // receive dma silent while an error blocks it
  property p_block_on_err;
    @(posedge sys_clk) disable iff (reset)
      dmacr_q[DMA_ON_ERR_BIT] && err_pending
      |-> !rx_dma_single_request && !rx_dma_burst_request;
  endproperty
  a_block_on_err: assert property (p_block_on_err)
    else $error("rx dma request during blocked error");

  // transmit dma needs its enable
  property p_tx_enable;
    @(posedge sys_clk) disable iff (reset)
      !dmacr_q[TX_DMA_EN_BIT] |-> !tx_dma_single_request &&
                                  !tx_dma_burst_request;
  endproperty
  a_tx_enable: assert property (p_tx_enable)
    else $error("tx dma request while disabled");

  // receive dma needs its enable
  property p_rx_enable;
    @(posedge sys_clk) disable iff (reset)
      !dmacr_q[RX_DMA_EN_BIT] |-> !rx_dma_single_request &&
                                  !rx_dma_burst_request;
  endproperty
  a_rx_enable: assert property (p_rx_enable)
    else $error("rx dma request while disabled");

  // burst only with a full watermark, and only together with single
  property p_rx_burst;
    @(posedge sys_clk) disable iff (reset)
      rx_dma_burst_request |-> rx_fifo_count >= rx_watermark &&
                               rx_dma_single_request;
  endproperty
  a_rx_burst: assert property (p_rx_burst)
    else $error("rx burst below watermark");

  // break event with mask set shows in status and interrupt next cycle
  property p_break_seen;
    @(posedge sys_clk) disable iff (reset)
      break_evt && mask_q[BREAK_BIT] && !(wr_en && hit_mask)
      |=> masked_irq_status[BREAK_BIT] && uart_irq;
  endproperty
  a_break_seen: assert property (p_break_seen)
    else $error("break event missing from masked status");

  // overrun request tracks its live input without delay
  property p_overrun_live;
    @(posedge sys_clk) disable iff (reset)
      masked_irq_status[OVERRUN_BIT] ==
        (overrun_live && mask_q[OVERRUN_BIT]);
  endproperty
  a_overrun_live: assert property (p_overrun_live)
    else $error("overrun status not live");

  // dma control upper bits read back as zero
  property p_dmacr_read;
    @(posedge sys_clk) disable iff (reset)
      setup_phase && !pwrite && hit_dmacr
      |=> prdata == {29'h0000_0000, $past(dmacr_q)};
  endproperty
  a_dmacr_read: assert property (p_dmacr_read)
    else $error("dma control read back wrong");
endmodule

// ### verif/dma_ctrl_model.sv
`timescale 1ns/1ps
module dma_ctrl_model #(
  parameter int W = 6
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] load_count,
  input  wire logic [W-1:0] watermark,
  input  wire logic         single_req,
  input  wire logic         burst_req,
  output logic      [W-1:0] count,
  output logic      [7:0]   bursts,
  output logic      [7:0]   singles
);
  // drains the receive fifo: a watermark per burst, one byte per single
  always_ff @(posedge sys_clk)
  begin
    if (reset || load)
    begin
      count   <= reset ? '0 : load_count;
      bursts  <= 8'h00;
      singles <= 8'h00;
    end
    else if (burst_req)
    begin
      count  <= count - watermark;
      bursts <= bursts + 8'h01;
    end
    else if (single_req)
    begin
      count   <= count - 1'b1;
      singles <= singles + 8'h01;
    end
  end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import uart_irq_pkg::*;
;
  logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, e, ovr = 0, irq, rxs, rxb, txs, txb;
  logic [5:0]  ev = '0;
  logic [3:0]  modem = '0;
  logic [5:0]  cnt, txsp = '0, rwm = 6'h04, twm = '0, ldc = '0;
  logic        ld = 0;
  logic [7:0]  nb, ns;
  int          err_total = 0, checks = 0, cycles = 0;

  // 100 ns bus clock
  always #50 sys_clk = ~sys_clk;

  uart_irq_status_dma_ctrl i_uart_irq_status_dma_ctrl (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overrun_live(ovr),
    .break_evt(ev[5]), .parity_evt(ev[4]), .framing_evt(ev[3]),
    .rx_timeout_evt(ev[2]), .tx_evt(ev[1]), .rx_evt(ev[0]),
    .modem_pins(modem), .rx_fifo_count(cnt), .tx_fifo_space(txsp),
    .rx_watermark(rwm), .tx_watermark(twm), .uart_irq(irq),
    .rx_dma_single_request(rxs), .rx_dma_burst_request(rxb),
    .tx_dma_single_request(txs), .tx_dma_burst_request(txb));

  dma_ctrl_model i_dma_ctrl_model (
    .sys_clk(sys_clk), .reset(reset), .load(ld), .load_count(ldc),
    .watermark(rwm), .single_req(rxs), .burst_req(rxb), .count(cnt),
    .bursts(nb), .singles(ns));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask

  // one apb transfer, setup then access, answer taken at the access edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(negedge sys_clk);
    psel = 1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge sys_clk);
    penable = 1;
    @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    @(negedge sys_clk);
    psel = 0;
    penable = 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, '0);
    chk("prdata", x, q);
  endtask

  // one-cycle pulse on an event input
  task automatic pulse(input int i);
    @(negedge sys_clk);
    ev[i] = 1;
    @(negedge sys_clk);
    ev[i] = 0;
  endtask

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      stop_test;
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 0;
    rd(MIS_OFFSET, 32'h0);
    rd(DMACR_OFFSET, 32'h0);
    chk("irq", 0, irq);
    $display("reset test done");
    apb(1, MASK_OFFSET, 32'h7ff);
    rd(MASK_OFFSET, 32'h7ff);
    for (int i = 0; i < 6; i++)
    begin
      pulse(i);
      rd(MIS_OFFSET, 32'h1 << (i + 4));
      chk("irq", 1, irq);
      apb(1, ICR_OFFSET, 32'h1 << (i + 4));
      rd(MIS_OFFSET, 32'h0);
    end
    pulse(3);
    pulse(5);
    apb(1, ICR_OFFSET, 32'h57f);
    rd(MIS_OFFSET, 32'h280);
    apb(1, ICR_OFFSET, 32'h280);
    rd(MIS_OFFSET, 32'h0);
    @(negedge sys_clk);
    ovr = 1;
    apb(1, ICR_OFFSET, 32'h400);
    rd(MIS_OFFSET, 32'h400);
    ovr = 0;
    rd(MIS_OFFSET, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      modem[i] = ~modem[i];
      repeat (4) @(negedge sys_clk);
      rd(MIS_OFFSET, 32'h1 << i);
      apb(1, ICR_OFFSET, 32'h1 << i);
      rd(MIS_OFFSET, 32'h0);
    end
    apb(1, MASK_OFFSET, 32'h5ff);
    pulse(5);
    rd(MIS_OFFSET, 32'h0);
    chk("irq", 0, irq);
    apb(1, ICR_OFFSET, 32'h200);
    apb(1, MASK_OFFSET, 32'h7ff);
    $display("status test done");
    txsp = 6'h05;
    twm = 6'h04;
    ld = 1;
    ldc = 6'h05;
    @(negedge sys_clk);
    ld = 0;
    chk("tx req", 0, {txb, txs});
    apb(1, DMACR_OFFSET, 32'hffff_fffa);
    rd(DMACR_OFFSET, 32'h2);
    chk("tx req", 3, {txb, txs});
    chk("rx req", 0, {rxb, rxs});
    pulse(3);
    apb(1, DMACR_OFFSET, 32'h7);
    chk("rx req", 0, {rxb, rxs});
    apb(1, ICR_OFFSET, 32'h80);
    chk("rx req", 3, {rxb, rxs});
    ld = 1;
    ldc = 6'd19;
    @(negedge sys_clk);
    ld = 0;
    for (int k = 0; k < 100 && cnt !== 6'h0; k++)
      @(negedge sys_clk);
    chk("bursts", 4, nb);
    chk("singles", 3, ns);
    $display("dma test done");
    apb(0, 12'h0f0, '0);
    chk("pslverr", 1, e);
    chk("pready", 1, pready);
    chk("unmapped", 0, q);
    rd(ICR_OFFSET, 32'h0);
    $display("access test done");
    stop_test;
  end
endmodule
